// >>> sabr_params.svh
/*
 * offsets, field positions, reset values and limits of the autobuffer and
 * status register bank; included by the bank's design file, no code inside.
 */
`ifndef SABR_PARAMS_SVH
`define SABR_PARAMS_SVH

// -----------------------------------------------------------------
// register offsets (7-bit control-port address)
// -----------------------------------------------------------------
`define SABR_OFF_CTRL      7'h11
`define SABR_OFF_RATIO_HI  7'h12
`define SABR_OFF_RATIO_LO  7'h13
`define SABR_OFF_PRE_C_HI  7'h14
`define SABR_OFF_PRE_C_LO  7'h15
`define SABR_OFF_PRE_D_HI  7'h16
`define SABR_OFF_PRE_D_LO  7'h17

// -----------------------------------------------------------------
// autobuffer control fields and reset value
// -----------------------------------------------------------------
`define SABR_BIT_PAD_EN    6
`define SABR_BIT_USER_EN   5
`define SABR_BIT_CS_EN     4
`define SABR_CTRL_WMASK    8'h7F
`define SABR_CTRL_RESET    8'h00
`define SABR_PAD_MAX       4'h8

// -----------------------------------------------------------------
// user-bit buffer shape
// -----------------------------------------------------------------
`define SABR_FIFO_WIDTH    9
`define SABR_FIFO_DEPTH    4

`endif

// >>> sabr_pkg.sv
/*
 * types shared by the autobuffer register bank.
 * assumes nothing of its surroundings.
 */
`default_nettype none
package sabr_pkg;

    // output stage of the user-bit path
    typedef enum logic [0:0] {
        SABR_PASS = 1'b0,
        SABR_PAD  = 1'b1
    } sabr_pad_state_t;

endpackage
`default_nettype wire

// >>> sabr_regs.sv
/*
 * autobuffer control register, sample rate ratio and burst preamble status
 * registers, plus the user-bit and channel-status copy path from receiver
 * to transmitter with zero padding between information units.
 * assumes: register port, receiver and transmitter cores all run on sys_clk;
 * status inputs are stable levels from the receiver and rate converter.
 */
// Contract
// - padding between units only when enabled
// - user bits copied only while enabled
// - channel status copied only while enabled
// - pad count field, ceiling of eight
// - fifteen-bit ratio in two bytes
// - preamble C word in two bytes
// - preamble C reads zero without burst data
// - upper preamble D byte readable
// - lower D byte: channel-B C in subframe mode
`timescale 1ns/100ps
`default_nettype none
`include "sabr_params.svh"

// -----------------------------------------------------------------
// user-bit buffer
// -----------------------------------------------------------------
module sabr_fifo #(
    parameter int WIDTH = `SABR_FIFO_WIDTH,
    parameter int DEPTH = `SABR_FIFO_DEPTH
) (
    input  wire logic             sys_clk,
    input  wire logic             reset,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
    logic [AW:0]      count, next_count;
    logic             next_in_ready, next_out_valid, push, pop;
    // pointer and flag update; flags kept as flops so ports come from registers
    always_comb begin
        push           = in_valid && in_ready;
        pop            = out_ready && out_valid;
        next_wr_ptr    = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr    = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count     = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        next_in_ready  = next_count != DEPTH[AW:0];
        next_out_valid = next_count != '0;
    end
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            count     <= '0;
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            wr_ptr    <= next_wr_ptr;
            rd_ptr    <= next_rd_ptr;
            count     <= next_count;
            in_ready  <= next_in_ready;
            out_valid <= next_out_valid;
        end
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
    assign out_data = mem[rd_ptr];
endmodule

// -----------------------------------------------------------------
// register bank and copy path
// -----------------------------------------------------------------
module sabr_regs (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [6:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    input  wire logic        rx_user_valid,
    input  wire logic [7:0]  rx_user_data,
    input  wire logic        rx_user_unit_end,
    output logic             rx_user_ready,
    output logic             tx_user_valid,
    output logic      [7:0]  tx_user_data,
    output logic             tx_user_unit_end,
    input  wire logic        tx_user_ready,
    input  wire logic        rx_cs_valid,
    input  wire logic        rx_cs_bit,
    output logic             tx_cs_valid,
    output logic             tx_cs_bit,
    input  wire logic [14:0] rate_ratio,
    input  wire logic [15:0] burst_preamble_c,
    input  wire logic [15:0] burst_preamble_d,
    input  wire logic [15:0] burst_preamble_c_b,
    input  wire logic        nonaudio_detected,
    input  wire logic        subframe_nonaudio
);
    logic [7:0]                ctrl, next_ctrl, next_rdata;
    logic                      next_cs_valid, next_cs_bit;
    sabr_pkg::sabr_pad_state_t state, next_state;
    logic [3:0]                pad_left, next_pad_left, pad_limit;
    logic                      next_tx_valid, next_tx_end, fifo_pop, fifo_out_valid;
    logic [7:0]                next_tx_data;
    logic [8:0]                fifo_out_data;
    logic                      unit_gap_padding_enable, user_bit_passthrough_enable;
    logic                      chan_status_passthrough_enable;

    assign unit_gap_padding_enable        = ctrl[`SABR_BIT_PAD_EN];
    assign user_bit_passthrough_enable    = ctrl[`SABR_BIT_USER_EN];
    assign chan_status_passthrough_enable = ctrl[`SABR_BIT_CS_EN];

    // read decode: status bytes, burst preambles masked without burst data except the lower D byte in subframe mode
    function automatic logic [7:0] sabr_read(input logic [6:0] a, input logic [7:0] c);
        logic [7:0] r;
        case (a)
            `SABR_OFF_CTRL:     r = c;
            `SABR_OFF_RATIO_HI: r = {1'b0, rate_ratio[14:8]};
            `SABR_OFF_RATIO_LO: r = rate_ratio[7:0];
            `SABR_OFF_PRE_C_HI: r = nonaudio_detected ? burst_preamble_c[15:8] : 8'h00;
            `SABR_OFF_PRE_C_LO: r = nonaudio_detected ? burst_preamble_c[7:0] : 8'h00;
            `SABR_OFF_PRE_D_HI: r = nonaudio_detected ? burst_preamble_d[15:8] : 8'h00;
            `SABR_OFF_PRE_D_LO: begin
                if (subframe_nonaudio) begin
                    r = burst_preamble_c_b[15:8];
                end else begin
                    r = nonaudio_detected ? burst_preamble_d[7:0] : 8'h00;
                end
            end
            default:            r = 8'h00;
        endcase
        return r;
    endfunction

    // register port: only the control byte takes writes, bit 7 stays zero
    always_comb begin
        next_ctrl  = ctrl;
        next_rdata = reg_rdata;
        if (reg_wr && reg_addr == `SABR_OFF_CTRL) begin
            next_ctrl = reg_wdata & `SABR_CTRL_WMASK;
        end
        if (reg_rd) begin
            next_rdata = sabr_read(reg_addr, ctrl);
        end
    end

    // channel status copy, one bit per receiver strobe
    always_comb begin
        next_cs_valid = rx_cs_valid && chan_status_passthrough_enable;
        next_cs_bit   = rx_cs_bit;
    end
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ctrl        <= `SABR_CTRL_RESET;
            reg_rdata   <= 8'h00;
            tx_cs_valid <= 1'b0;
            tx_cs_bit   <= 1'b0;
        end else begin
            ctrl        <= next_ctrl;
            reg_rdata   <= next_rdata;
            tx_cs_valid <= next_cs_valid;
            tx_cs_bit   <= next_cs_bit;
        end
    end

    // user bytes dropped at the door while copying is off
    sabr_fifo #(
        .WIDTH (`SABR_FIFO_WIDTH),
        .DEPTH (`SABR_FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .in_valid  (rx_user_valid && user_bit_passthrough_enable),
        .in_data   ({rx_user_unit_end, rx_user_data}),
        .in_ready  (rx_user_ready),
        .out_valid (fifo_out_valid),
        .out_data  (fifo_out_data),
        .out_ready (fifo_pop)
    );

    // codes above eight clamp to eight
    assign pad_limit = (ctrl[3:0] > `SABR_PAD_MAX) ? `SABR_PAD_MAX : ctrl[3:0];

    // output stage: pass unit bytes, then zero bytes after each unit end
    always_comb begin
        next_state    = state;
        next_pad_left = pad_left;
        next_tx_valid = tx_user_valid;
        next_tx_data  = tx_user_data;
        next_tx_end   = tx_user_unit_end;
        fifo_pop      = 1'b0;
        if (!tx_user_valid || tx_user_ready) begin
            next_tx_valid = 1'b0;
            case (state)
                sabr_pkg::SABR_PASS: begin
                    if (fifo_out_valid) begin
                        fifo_pop      = 1'b1;
                        next_tx_valid = 1'b1;
                        next_tx_data  = fifo_out_data[7:0];
                        next_tx_end   = fifo_out_data[8];
                        if (fifo_out_data[8] && unit_gap_padding_enable && pad_limit != 4'h0) begin
                            next_state    = sabr_pkg::SABR_PAD;
                            next_pad_left = pad_limit;
                        end
                    end
                end
                sabr_pkg::SABR_PAD: begin
                    next_tx_valid = 1'b1;
                    next_tx_data  = 8'h00;
                    next_tx_end   = 1'b0;
                    next_pad_left = pad_left - 4'h1;
                    if (pad_left == 4'h1) begin
                        next_state = sabr_pkg::SABR_PASS;
                    end
                end
                default: next_state = sabr_pkg::SABR_PASS;
            endcase
        end
    end
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state            <= sabr_pkg::SABR_PASS;
            pad_left         <= 4'h0;
            tx_user_valid    <= 1'b0;
            tx_user_data     <= 8'h00;
            tx_user_unit_end <= 1'b0;
        end else begin
            state            <= next_state;
            pad_left         <= next_pad_left;
            tx_user_valid    <= next_tx_valid;
            tx_user_data     <= next_tx_data;
            tx_user_unit_end <= next_tx_end;
        end
    end

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    sequence s_pad_entry;
        state == sabr_pkg::SABR_PASS ##1 state == sabr_pkg::SABR_PAD;
    endsequence
    property p_no_pad_when_off;
        @(posedge sys_clk) disable iff (reset)
        (state == sabr_pkg::SABR_PASS && !unit_gap_padding_enable) |=> state == sabr_pkg::SABR_PASS;
    endproperty
    a_no_pad_when_off: assert property (p_no_pad_when_off) else $error("padding entered while disabled");
    property p_user_stop;
        @(posedge sys_clk) disable iff (reset)
        (!user_bit_passthrough_enable && !fifo_out_valid && !reg_wr) |=> !fifo_out_valid;
    endproperty
    a_user_stop: assert property (p_user_stop) else $error("user byte buffered while copy off");
    property p_cs_copy;
        @(posedge sys_clk) disable iff (reset)
        rx_cs_valid |=> tx_cs_valid == $past(chan_status_passthrough_enable) && tx_cs_bit == $past(rx_cs_bit);
    endproperty
    a_cs_copy: assert property (p_cs_copy) else $error("channel status copy wrong");
    property p_pad_count;
        @(posedge sys_clk) disable iff (reset)
        s_pad_entry |-> pad_left != 4'h0 && pad_left <= `SABR_PAD_MAX && pad_left == $past(pad_limit);
    endproperty
    a_pad_count: assert property (p_pad_count) else $error("pad count out of range");
    property p_ratio_hi;
        @(posedge sys_clk) disable iff (reset)
        (reg_rd && reg_addr == `SABR_OFF_RATIO_HI) |=> reg_rdata == {1'b0, $past(rate_ratio[14:8])};
    endproperty
    a_ratio_hi: assert property (p_ratio_hi) else $error("ratio upper byte wrong");
    property p_pre_c_lo;
        @(posedge sys_clk) disable iff (reset)
        (reg_rd && reg_addr == `SABR_OFF_PRE_C_LO)
            |=> reg_rdata == ($past(nonaudio_detected) ? $past(burst_preamble_c[7:0]) : 8'h00);
    endproperty
    a_pre_c_lo: assert property (p_pre_c_lo) else $error("preamble C lower byte wrong");
    property p_pre_d_hi;
        @(posedge sys_clk) disable iff (reset)
        (reg_rd && reg_addr == `SABR_OFF_PRE_D_HI && nonaudio_detected)
            |=> reg_rdata == $past(burst_preamble_d[15:8]);
    endproperty
    a_pre_d_hi: assert property (p_pre_d_hi) else $error("preamble D upper byte wrong");
    property p_pre_d_lo_sub;
        @(posedge sys_clk) disable iff (reset)
        (reg_rd && reg_addr == `SABR_OFF_PRE_D_LO && subframe_nonaudio)
            |=> reg_rdata == $past(burst_preamble_c_b[15:8]);
    endproperty
    a_pre_d_lo_sub: assert property (p_pre_d_lo_sub) else $error("subframe lower D byte wrong");
    property p_ro_write;
        @(posedge sys_clk) disable iff (reset)
        (reg_wr && reg_addr != `SABR_OFF_CTRL) |=> ctrl == $past(ctrl);
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("read-only write changed control");
endmodule
`default_nettype wire

// >>> sabr_partner.sv
/*
 * stream source and sink standing on the far side of the user-bit copy path.
 * assumes: driven from one testbench on sys_clk; send is entered just after
 * a rising edge, and idle is called once a burst is over.
 */
`timescale 1ns/100ps
`default_nettype none

// -----------------------------------------------------------------
// receiver-side source, transmitter-side sink
// -----------------------------------------------------------------
module sabr_partner (
    input  wire logic       sys_clk,
    input  wire logic       stall,
    output logic            rx_user_valid,
    output logic      [7:0] rx_user_data,
    output logic            rx_user_unit_end,
    input  wire logic       rx_user_ready,
    input  wire logic       tx_user_valid,
    input  wire logic [7:0] tx_user_data,
    input  wire logic       tx_user_unit_end,
    output logic            tx_user_ready
);
    logic [8:0] got [$];   // {unit_end, data} in arrival order

    // idle lines carry junk, never a stale byte
    initial begin
        rx_user_valid = 1'b0;
        rx_user_data = 8'hA5;
        rx_user_unit_end = 1'b1;
    end

    // hold the byte until an edge sees ready; byte and valid stay put so the
    // next call changes each line only once in its time step
    task automatic send(input logic [7:0] data, input logic unit_end);
        rx_user_data = data;
        rx_user_unit_end = unit_end;
        rx_user_valid = 1'b1;
        @(posedge sys_clk);
        while (rx_user_ready !== 1'b1) @(posedge sys_clk);
        #1;
    endtask

    // release the source after a burst; released lines show the inverse
    task automatic idle;
        rx_user_valid = 1'b0;
        rx_user_data = ~rx_user_data;
        rx_user_unit_end = ~rx_user_unit_end;
    endtask

    // sink: stalls on command, records every byte taken
    assign tx_user_ready = !stall;
    always @(posedge sys_clk) begin
        if (tx_user_valid === 1'b1 && tx_user_ready)
            got.push_back({tx_user_unit_end, tx_user_data});
    end
endmodule

`default_nettype wire

// >>> sabr_regs_test.sv
/*
 * self-checking bench for the autobuffer register bank and copy paths.
 * assumes: sabr_regs and sabr_partner compiled first; one 25 MHz clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "sabr_params.svh"

module sabr_regs_test;
    logic        sys_clk, reset, reg_wr, reg_rd, stall;
    logic [6:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, rx_user_data, tx_user_data;
    logic        rx_user_valid, rx_user_unit_end, rx_user_ready;
    logic        tx_user_valid, tx_user_unit_end, tx_user_ready;
    logic        rx_cs_valid, rx_cs_bit, tx_cs_valid, tx_cs_bit;
    logic [14:0] rate_ratio;
    logic [15:0] burst_preamble_c, burst_preamble_d, burst_preamble_c_b;
    logic        nonaudio_detected, subframe_nonaudio;
    int          miscompares = 0;
    int          n_checks = 0;

    sabr_regs i_sabr_regs (.sys_clk(sys_clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .rx_user_valid(rx_user_valid), .rx_user_data(rx_user_data), .rx_user_unit_end(rx_user_unit_end),
        .rx_user_ready(rx_user_ready), .tx_user_valid(tx_user_valid), .tx_user_data(tx_user_data),
        .tx_user_unit_end(tx_user_unit_end), .tx_user_ready(tx_user_ready), .rx_cs_valid(rx_cs_valid),
        .rx_cs_bit(rx_cs_bit), .tx_cs_valid(tx_cs_valid), .tx_cs_bit(tx_cs_bit), .rate_ratio(rate_ratio),
        .burst_preamble_c(burst_preamble_c), .burst_preamble_d(burst_preamble_d),
        .burst_preamble_c_b(burst_preamble_c_b), .nonaudio_detected(nonaudio_detected),
        .subframe_nonaudio(subframe_nonaudio));

    sabr_partner i_sabr_partner (.sys_clk(sys_clk), .stall(stall), .rx_user_valid(rx_user_valid),
        .rx_user_data(rx_user_data), .rx_user_unit_end(rx_user_unit_end), .rx_user_ready(rx_user_ready),
        .tx_user_valid(tx_user_valid), .tx_user_data(tx_user_data), .tx_user_unit_end(tx_user_unit_end),
        .tx_user_ready(tx_user_ready));

    // -----------------------------------------------------------------
    // clock, compare, register access
    // -----------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // each access starts on a fresh edge so strobes never toggle twice in a step
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1 reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge sys_clk);
        #1 reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask

    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp, input string what);
        @(posedge sys_clk);
        #1 reg_rd = 1'b1;
        reg_addr = a;
        @(posedge sys_clk);
        #1 reg_rd = 1'b0;
        chk({1'b0, reg_rdata}, {1'b0, exp}, what);
    endtask

    // one status bit through the copy path, strobe only when enabled
    task automatic cs_pulse(input logic b, input logic en);
        @(posedge sys_clk);
        #1 rx_cs_valid = 1'b1;
        rx_cs_bit = b;
        @(posedge sys_clk);
        #1 rx_cs_valid = 1'b0;
        rx_cs_bit = ~b;
        chk({8'h00, tx_cs_valid}, {8'h00, en}, "cs strobe");
        if (en) chk({8'h00, tx_cs_bit}, {8'h00, b}, "cs bit");
        @(posedge sys_clk);
        #1 chk({8'h00, tx_cs_valid}, 9'h000, "cs strobe width");
    endtask

    // a unit end byte then a plain byte; padding may only follow the first
    task automatic unit_run(input logic [7:0] ctrl, input int zeros);
        int n;
        n = ctrl[5] ? zeros + 2 : 0;
        wr(`SABR_OFF_CTRL, ctrl);
        i_sabr_partner.got.delete();
        @(posedge sys_clk);
        #1 i_sabr_partner.send(8'hA5, 1'b1);
        i_sabr_partner.send(8'h3C, 1'b0);
        i_sabr_partner.idle();
        repeat (30) @(posedge sys_clk);
        #1 chk(9'(i_sabr_partner.got.size()), 9'(n), "unit length");
        if (n != 0 && i_sabr_partner.got.size() == n) begin
            chk(i_sabr_partner.got[0], 9'h1A5, "unit end byte");
            for (int i = 1; i <= zeros; i++) chk(i_sabr_partner.got[i], 9'h000, "pad byte");
            chk(i_sabr_partner.got[n-1], 9'h03C, "next byte");
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        #(40 * 20000);
        miscompares++;
        stop_test();
    end

    // -----------------------------------------------------------------
    // tests
    // -----------------------------------------------------------------
    initial begin
        reset = 1'b1;
        {reg_wr, reg_rd, reg_addr, reg_wdata, stall, rx_cs_valid, rx_cs_bit} = '0;
        rate_ratio = 15'h6A3C;
        burst_preamble_c = 16'hC3A1;
        burst_preamble_d = 16'hD47E;
        burst_preamble_c_b = 16'hB29F;
        {nonaudio_detected, subframe_nonaudio} = 2'b00;
        repeat (2) @(posedge sys_clk);
        #1 reset = 1'b0;
        rd_chk(`SABR_OFF_CTRL, 8'h00, "ctrl reset");
        rd_chk(7'h20, 8'h00, "unmapped read");
        wr(`SABR_OFF_CTRL, 8'hFF);
        rd_chk(`SABR_OFF_CTRL, 8'h7F, "ctrl fields");
        $display("test control register done");
        rd_chk(`SABR_OFF_RATIO_HI, 8'h6A, "ratio upper");
        rd_chk(`SABR_OFF_RATIO_LO, 8'h3C, "ratio lower");
        rd_chk(`SABR_OFF_PRE_C_HI, 8'h00, "c upper idle");
        rd_chk(`SABR_OFF_PRE_C_LO, 8'h00, "c lower idle");
        rd_chk(`SABR_OFF_PRE_D_LO, 8'h00, "d lower idle");
        nonaudio_detected = 1'b1;
        rd_chk(`SABR_OFF_PRE_C_HI, 8'hC3, "c upper");
        rd_chk(`SABR_OFF_PRE_C_LO, 8'hA1, "c lower");
        rd_chk(`SABR_OFF_PRE_D_HI, 8'hD4, "d upper");
        rd_chk(`SABR_OFF_PRE_D_LO, 8'h7E, "d lower");
        subframe_nonaudio = 1'b1;
        rd_chk(`SABR_OFF_PRE_D_LO, 8'hB2, "d lower subframe");
        for (int a = 'h12; a <= 'h17; a++) wr(a[6:0], 8'h55);
        rd_chk(`SABR_OFF_RATIO_HI, 8'h6A, "ratio after write");
        rd_chk(`SABR_OFF_PRE_C_LO, 8'hA1, "c after write");
        rd_chk(`SABR_OFF_PRE_D_LO, 8'hB2, "d after write");
        rd_chk(`SABR_OFF_CTRL, 8'h7F, "ctrl after write");
        $display("test status registers done");
        wr(`SABR_OFF_CTRL, 8'h10);
        cs_pulse(1'b1, 1'b1);
        cs_pulse(1'b0, 1'b1);
        wr(`SABR_OFF_CTRL, 8'h00);
        cs_pulse(1'b1, 1'b0);
        $display("test channel status done");
        unit_run(8'h64, 4);
        unit_run(8'h24, 0);
        unit_run(8'h6F, 8);
        unit_run(8'h68, 8);
        unit_run(8'h60, 0);
        unit_run(8'h41, 0);
        $display("test user padding done");
        // stalled sink: buffer plus output stage fill, then drain in order
        wr(`SABR_OFF_CTRL, 8'h20);
        i_sabr_partner.got.delete();
        stall = 1'b1;
        @(posedge sys_clk);
        #1 for (int i = 0; i < 5; i++) i_sabr_partner.send(8'h10 + 8'(i), 1'b0);
        i_sabr_partner.idle();
        repeat (3) @(posedge sys_clk);
        #1 chk({8'h00, rx_user_ready}, 9'h000, "full refuses");
        stall = 1'b0;
        repeat (20) @(posedge sys_clk);
        #1 chk(9'(i_sabr_partner.got.size()), 9'd5, "drained count");
        for (int i = 0; i < 5 && i < i_sabr_partner.got.size(); i++) begin
            chk(i_sabr_partner.got[i], 9'h010 + 9'(i), "drained byte");
        end
        $display("test buffer fill done");
        stop_test();
    end
endmodule

`default_nettype wire
